// ===== troc_pkg.sv
// Purpose: constants and carrier types for the receive overhead capture bank
// Assumes: one 50 MHz clock, AHB-Lite register access, word per register
// Notes:   offsets are register indices; byte address is four times the index

package troc_pkg;

  // port replication
  localparam int unsigned PORTS_MAX   = 4;
  localparam logic [10:0] PORT_STRIDE = 11'h200;

  // register indices within one port
  localparam logic [8:0] IDX_MON_BYTE   = 9'h060;
  localparam logic [8:0] IDX_DL_STATUS  = 9'h062;
  localparam logic [8:0] IDX_BIT_CODE   = 9'h063;
  localparam logic [8:0] IDX_SLC_ALIGN  = 9'h064;
  localparam logic [8:0] IDX_SLC_NALIGN = 9'h065;
  localparam logic [8:0] IDX_SLC_SIEVEN = 9'h066;
  localparam logic [8:0] IDX_SI_ODD     = 9'h067;
  localparam logic [8:0] IDX_REM_ALARM  = 9'h068;
  localparam logic [8:0] IDX_SA4_FRAMES = 9'h069;
  localparam logic [8:0] IDX_MON_SELECT = 9'h07E;
  localparam logic [8:0] IDX_T1_FORMAT  = 9'h07F;
  localparam logic [8:0] IDX_MASTER     = 9'h080;
  localparam logic [8:0] IDX_RX_CTRL1   = 9'h081;

  // field positions
  localparam int unsigned MODE_E1_BIT  = 0;
  localparam int unsigned CRC4_EN_BIT  = 3;
  localparam int unsigned SI_BIT       = 7;
  localparam int unsigned RA_BIT       = 5;
  localparam int unsigned SA4_BIT      = 4;

  // t1 framing formats
  localparam logic [1:0] FMT_ESF   = 2'h0;
  localparam logic [1:0] FMT_D4    = 2'h1;
  localparam logic [1:0] FMT_SLC96 = 2'h2;

  // counts and reset values
  localparam logic [5:0] SYNC_MAX  = 6'h3F;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam int unsigned SLC_BITS = 24;

  // decoded overhead from the framer of one port
  typedef struct packed {
    logic       mon_valid;
    logic [4:0] mon_slot;
    logic [2:0] mon_idx;
    logic       mon_bit;
    logic       dl_valid;
    logic       dl_bit;
    logic       mf_start;
    logic       boc_valid;
    logic [5:0] boc_code;
    logic       slc_valid;
    logic       slc_bit;
    logic       slc_end;
    logic       ts0_valid;
    logic       ts0_align;
    logic [3:0] ts0_frame;
    logic [7:0] ts0_byte;
    logic       crc_search;
    logic       cas_search;
    logic       fas_search;
    logic       crc_timeout;
    logic       crc_sync;
  } troc_line_type;

  // stored state of one port
  typedef struct packed {
    logic [7:0]          mon_sh;
    logic [7:0]          mon_r;
    logic [4:0]          mon_sel;
    logic [7:0]          dl_sh;
    logic [2:0]          dl_cnt;
    logic [7:0]          dl_r;
    logic [5:0]          boc_r;
    logic [SLC_BITS-1:0] slc_sh;
    logic [SLC_BITS-1:0] slc_r;
    logic [7:0]          af_r;
    logic [7:0]          naf_r;
    logic [7:0]          si_even;
    logic [7:0]          si_odd;
    logic [7:0]          ra;
    logic [7:0]          sa4;
    logic [5:0]          crc_sync_search_count;
    logic                mode_e1;
    logic                crc4_en;
    logic [1:0]          t1_fmt;
  } troc_port_type;

endpackage : troc_pkg

// ===== troc_rx_capture.sv
// Purpose: per-port receive overhead capture registers, read over AHB-Lite
// Assumes: framer strobes synchronous to ref_clk_i; word-only single transfers
// Notes:   zero wait states; read data registered in the data phase
//
// The implementer's own choice: the AHB-Lite slave port.

`timescale 1ns/1ns

module troc_rx_capture #(
  parameter int unsigned NUM_PORTS = troc_pkg::PORTS_MAX
) (
  // clock and reset
  input  wire logic                                    ref_clk_i,
  input  wire logic                                    reset_i,
  // ahb-lite slave
  input  wire logic                                    hsel_i,
  input  wire logic [31:0]                             haddr_i,
  input  wire logic [1:0]                              htrans_i,
  input  wire logic                                    hwrite_i,
  input  wire logic [2:0]                              hsize_i,
  input  wire logic                                    hready_i,
  input  wire logic [31:0]                             hwdata_i,
  output      logic [31:0]                             hrdata_o,
  output      logic                                    hreadyout_o,
  output      logic                                    hresp_o,
  // decoded overhead from the framers
  input  wire troc_pkg::troc_line_type [NUM_PORTS-1:0] line_i
);

  if (NUM_PORTS < 1 || NUM_PORTS > troc_pkg::PORTS_MAX) begin : g_bad_ports
    $error("NUM_PORTS must lie between 1 and PORTS_MAX");
  end

  typedef struct packed {
    troc_pkg::troc_port_type [NUM_PORTS-1:0] port;
    logic                                    wr_pend;
    logic [10:0]                             wr_idx;
    logic [31:0]                             rdata;
  } troc_state_type;

  troc_state_type state_r;
  troc_state_type state_nxt;

  // true when the offset names a register of this bank
  function automatic logic offset_known(input logic [8:0] off);
    case (off)
      troc_pkg::IDX_MON_BYTE,
      troc_pkg::IDX_DL_STATUS,
      troc_pkg::IDX_BIT_CODE,
      troc_pkg::IDX_SLC_ALIGN,
      troc_pkg::IDX_SLC_NALIGN,
      troc_pkg::IDX_SLC_SIEVEN,
      troc_pkg::IDX_SI_ODD,
      troc_pkg::IDX_REM_ALARM,
      troc_pkg::IDX_SA4_FRAMES,
      troc_pkg::IDX_MON_SELECT,
      troc_pkg::IDX_T1_FORMAT,
      troc_pkg::IDX_MASTER,
      troc_pkg::IDX_RX_CTRL1:   offset_known = 1'b1;
      default:                  offset_known = 1'b0;
    endcase
  endfunction : offset_known

  // true when a word index names a built port and a known offset; unmapped ports answer zero
  function automatic logic port_ok(input logic [10:0] idx);
    port_ok = (32'(idx[10:9]) < NUM_PORTS) && offset_known(idx[8:0]);
  endfunction : port_ok

  // read value of one register of one port
  function automatic logic [7:0] read_reg(input troc_pkg::troc_port_type p,
                                          input troc_pkg::troc_line_type l,
                                          input logic [8:0]              off);
    logic [7:0] v;
    v = troc_pkg::RST_BYTE;
    case (off)
      troc_pkg::IDX_MON_BYTE:   v = p.mon_r;
      troc_pkg::IDX_DL_STATUS: begin
        if (p.mode_e1) begin
          // live, nothing latched except the counter
          v = {p.crc_sync_search_count[5:2], p.crc_sync_search_count[0],
               l.crc_search,
               l.cas_search,
               l.fas_search};
        end else begin
          v = p.dl_r;
        end
      end
      troc_pkg::IDX_BIT_CODE:   v = p.mode_e1 ? 8'h00 : {2'h0, p.boc_r};
      troc_pkg::IDX_SLC_ALIGN:  v = p.mode_e1 ? p.af_r  : p.slc_r[7:0];
      troc_pkg::IDX_SLC_NALIGN: v = p.mode_e1 ? p.naf_r : p.slc_r[15:8];
      troc_pkg::IDX_SLC_SIEVEN: v = p.mode_e1 ? p.si_even : p.slc_r[23:16];
      troc_pkg::IDX_SI_ODD:     v = p.si_odd;
      troc_pkg::IDX_REM_ALARM:  v = p.ra;
      troc_pkg::IDX_SA4_FRAMES: v = p.sa4;
      troc_pkg::IDX_MON_SELECT: v = {3'h0, p.mon_sel};
      troc_pkg::IDX_T1_FORMAT:  v = {6'h00, p.t1_fmt};
      troc_pkg::IDX_MASTER:     v = {7'h00, p.mode_e1};
      troc_pkg::IDX_RX_CTRL1:   v = {4'h0, p.crc4_en, 3'h0};
      default:                  v = troc_pkg::RST_BYTE;
    endcase
    read_reg = v;
  endfunction : read_reg

  logic        addr_take;
  logic [10:0] addr_idx;

  // index bits above the bank must be zero to hit a register
  assign addr_take = hsel_i && htrans_i[1] && hready_i;
  assign addr_idx  = haddr_i[12:2];

  always_comb begin
    troc_pkg::troc_port_type p;
    troc_pkg::troc_line_type l;
    logic [7:0]              mon_tmp;
    logic [7:0]              dl_tmp;
    logic [troc_pkg::SLC_BITS-1:0] slc_tmp;
    logic [2:0]              fidx;
    logic [8:0]              woff;
    logic [7:0]              wb;
    p         = '0;
    l         = '0;
    mon_tmp   = '0;
    dl_tmp    = '0;
    slc_tmp   = '0;
    fidx      = '0;
    woff      = '0;
    wb        = '0;
    state_nxt = state_r;

    for (int i = 0; i < NUM_PORTS; i++) begin
      p = state_r.port[i];
      l = line_i[i];

      // host writes reach only the control registers
      woff = state_r.wr_idx[8:0];
      wb   = hwdata_i[7:0];
      if (state_r.wr_pend && 32'(state_r.wr_idx[10:9]) == i) begin
        case (woff)
          troc_pkg::IDX_MON_SELECT: p.mon_sel = wb[4:0];
          troc_pkg::IDX_T1_FORMAT:  p.t1_fmt  = wb[1:0];
          troc_pkg::IDX_MASTER:     p.mode_e1 = wb[troc_pkg::MODE_E1_BIT];
          troc_pkg::IDX_RX_CTRL1:   p.crc4_en = wb[troc_pkg::CRC4_EN_BIT];
          default:                  p.mon_sel = p.mon_sel;
        endcase
      end

      // channel monitor, shared by both modes
      mon_tmp = p.mon_sh;
      if (l.mon_valid && l.mon_slot == p.mon_sel) begin
        mon_tmp[3'(troc_pkg::BYTE_LAST - l.mon_idx)] = l.mon_bit;
        p.mon_sh = mon_tmp;
        if (l.mon_idx == troc_pkg::BYTE_LAST) begin
          p.mon_r = mon_tmp;
        end
      end

      if (!p.mode_e1) begin
        // data link: shift in at the top so the earliest ends lowest
        dl_tmp = p.dl_sh;
        if (l.dl_valid) begin
          dl_tmp   = {l.dl_bit, p.dl_sh[7:1]};
          p.dl_sh  = dl_tmp;
          p.dl_cnt = 3'(p.dl_cnt + 3'h1);
        end
        if (p.t1_fmt == troc_pkg::FMT_D4) begin
          if (l.mf_start) begin
            p.dl_r   = {2'h0, dl_tmp[7:2]};
            p.dl_cnt = 3'h0;
          end
        end else if (l.dl_valid && p.dl_cnt == 3'h0) begin
          p.dl_r = dl_tmp;
        end

        if (l.boc_valid) begin
          p.boc_r = l.boc_code;
        end

        // slc-96: c1 arrives first and lands in bit 0 of the first register
        slc_tmp = p.slc_sh;
        if (l.slc_valid) begin
          slc_tmp  = {l.slc_bit, p.slc_sh[troc_pkg::SLC_BITS-1:1]};
          p.slc_sh = slc_tmp;
        end
        if (p.t1_fmt == troc_pkg::FMT_SLC96 && l.slc_end) begin
          p.slc_r = slc_tmp;
        end
      end else if (l.ts0_valid) begin
        fidx = l.ts0_frame[3:1];
        if (l.ts0_align) begin
          p.af_r          = l.ts0_byte;
          p.si_even[fidx] = l.ts0_byte[troc_pkg::SI_BIT];
        end else begin
          p.naf_r        = l.ts0_byte;
          p.si_odd[fidx] = l.ts0_byte[troc_pkg::SI_BIT];
          p.ra[fidx]     = l.ts0_byte[troc_pkg::RA_BIT];
          p.sa4[fidx]    = l.ts0_byte[troc_pkg::SA4_BIT];
        end
      end

      // clear outranks a coincident timeout: sync has been reached
      if (!p.crc4_en || l.crc_sync) begin
        p.crc_sync_search_count = 6'h00;
      end else if (p.mode_e1 && l.crc_timeout &&
                   p.crc_sync_search_count != troc_pkg::SYNC_MAX) begin
        p.crc_sync_search_count = 6'(p.crc_sync_search_count + 6'h01);
      end

      state_nxt.port[i] = p;
    end

    // write data phase follows the taken address phase
    state_nxt.wr_pend = 1'b0;
    if (addr_take) begin
      state_nxt.wr_pend = hwrite_i && haddr_i[31:13] == 19'h0 && port_ok(addr_idx);
      state_nxt.wr_idx  = addr_idx;
      // read from the updated copy so a write just before is seen
      state_nxt.rdata   = 32'h0;
      if (!hwrite_i && haddr_i[31:13] == 19'h0 && port_ok(addr_idx)) begin
        for (int i = 0; i < NUM_PORTS; i++) begin
          if (32'(addr_idx[10:9]) == i) begin
            state_nxt.rdata = {24'h0, read_reg(state_nxt.port[i], line_i[i],
                                               addr_idx[8:0])};
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign hrdata_o    = state_r.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

endmodule : troc_rx_capture

// ===== troc_rx_capture_asserts.sv
// Purpose: bus-side checks of the overhead capture bank
// Assumes: port 0 mode is tracked from host writes to the master register
// Notes:   read data is judged one cycle after its address edge
`timescale 1ns/1ns
module troc_rx_capture_asserts #(
  parameter int unsigned NUM_PORTS = 4
) (
  // clock and reset
  input wire logic                                    ref_clk_i,
  input wire logic                                    reset_i,
  // ahb-lite
  input wire logic                                    hsel_i,
  input wire logic [31:0]                             haddr_i,
  input wire logic [1:0]                              htrans_i,
  input wire logic                                    hwrite_i,
  input wire logic [2:0]                              hsize_i,
  input wire logic                                    hready_i,
  input wire logic [31:0]                             hwdata_i,
  input wire logic [31:0]                             hrdata_o,
  input wire logic                                    hreadyout_o,
  input wire logic                                    hresp_o,
  // framers
  input wire troc_pkg::troc_line_type [NUM_PORTS-1:0] line_i
);
  logic tk;
  logic mw_r;
  logic e1_r;
  logic e1_now;
  assign tk = hsel_i & htrans_i[1] & hready_i;
  // a read right behind the mode write already sees the new mode
  assign e1_now = mw_r ? hwdata_i[0] : e1_r;
  // mode copy lands at the end of the write data phase, as in the bank
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mw_r <= 1'b0;
      e1_r <= 1'b0;
    end else begin
      mw_r <= tk & hwrite_i & (haddr_i == 32'h0000_0200);
      if (mw_r) begin
        e1_r <= hwdata_i[0];
      end
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_rd(logic [8:0] i);
    tk && !hwrite_i && haddr_i[31:2] == {21'h0, i};
  endsequence
  a_resp_okay: assert property (hresp_o == 1'b0) else $error("error response");
  a_ready_high: assert property (hreadyout_o == 1'b1) else $error("wait state");
  a_upper_zero: assert property (hrdata_o[31:8] == 24'h0) else $error("upper bits");
  a_reset_clear: assert property ($fell(reset_i) |-> hrdata_o == 32'h0)
    else $error("data after reset");
  a_unmapped_zero: assert property (tk && !hwrite_i && haddr_i[31:13] != 19'h0
    |=> hrdata_o == 32'h0) else $error("unmapped read");
  a_write_zero: assert property (tk && hwrite_i |=> hrdata_o == 32'h0)
    else $error("write phase data");
  a_code_top: assert property (s_rd(9'h063) |=> hrdata_o[7:6] == 2'h0)
    else $error("code top bits");
  a_e1_code: assert property (s_rd(9'h063) ##0 e1_now |=> hrdata_o == 32'h0)
    else $error("code in e1");
  a_live_status: assert property (s_rd(9'h062) ##0 e1_now |=> hrdata_o[2:0] ==
    {$past(line_i[0].crc_search), $past(line_i[0].cas_search), $past(line_i[0].fas_search)})
    else $error("live status");
endmodule : troc_rx_capture_asserts

bind troc_rx_capture troc_rx_capture_asserts #(.NUM_PORTS(NUM_PORTS)) u_asserts (
  .ref_clk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
  .hready_i, .hwdata_i, .hrdata_o, .hreadyout_o, .hresp_o, .line_i);

// ===== troc_line_model.sv
// Purpose: far-end framer model driving decoded overhead strobes
// Assumes: called right after a rising edge
// Notes:   an idle cycle follows each strobe; levels persist
`timescale 1ns/1ns
module troc_line_model #(
  parameter int unsigned NP = 1
) (
  // clock
  input  wire logic                             ref_clk_i,
  // decoded overhead per port
  output      troc_pkg::troc_line_type [NP-1:0] line_o
);
  logic [2:0] lvl_r = 3'h0;
  initial line_o = '0;
  function automatic troc_pkg::troc_line_type lv(input troc_pkg::troc_line_type v);
    lv            = v;
    lv.crc_search = lvl_r[2];
    lv.cas_search = lvl_r[1];
    lv.fas_search = lvl_r[0];
  endfunction : lv
  task automatic pulse(input int p, input troc_pkg::troc_line_type v);
    line_o[p] <= lv(v);
    @(posedge ref_clk_i);
    line_o[p] <= lv('0);
    @(posedge ref_clk_i);
  endtask : pulse
  task automatic level(input logic [2:0] l);
    lvl_r = l;
    for (int p = 0; p < NP; p++) begin
      line_o[p] <= lv('0);
    end
    @(posedge ref_clk_i);
  endtask : level
endmodule : troc_line_model

// ===== troc_rx_capture_test.sv
// Purpose: self-checking bench of the overhead capture bank
// Assumes: two ports built, so port 2 decodes as unmapped; port 4 falls above the bank
// Notes:   each scenario judges its own reads before returning
`timescale 1ns/1ns
module troc_rx_capture_test;
  localparam int unsigned NP = 2;
  logic                             ref_clk_i   = 1'b0;
  logic                             reset_i     = 1'b1;
  logic                             hsel_i      = 1'b0;
  logic [31:0]                      haddr_i     = 32'h0;
  logic [1:0]                       htrans_i    = 2'h0;
  logic                             hwrite_i    = 1'b0;
  logic [31:0]                      hwdata_i    = 32'h0;
  logic [31:0]                      hrdata_o;
  logic                             hreadyout_o;
  logic                             hresp_o;
  troc_pkg::troc_line_type [NP-1:0] line_i;
  troc_pkg::troc_line_type          v;
  logic [31:0]                      q;
  int                               err_total   = 0;
  int                               comparisons = 0;
  int                               cyc         = 0;
  troc_rx_capture #(.NUM_PORTS(NP)) u_troc_rx_capture (
    .ref_clk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i(3'h2), .hready_i(hreadyout_o), .hwdata_i, .hrdata_o,
    .hreadyout_o, .hresp_o, .line_i);
  troc_line_model #(.NP(NP)) u_troc_line_model (.ref_clk_i, .line_o(line_i));
  always #10 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("counts: %0d compared, %0d mismatched", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel_i   <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i  <= a;
    hwrite_i <= w;
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    q = hrdata_o;
  endtask : ahb
  function automatic logic [31:0] adr(input int p, input logic [8:0] i);
    adr = 32'(p) * 32'h800 + {21'h0, i, 2'h0};
  endfunction : adr
  task automatic wr(input int p, input logic [8:0] i, input logic [7:0] d);
    ahb(1'b1, adr(p, i), {24'h0, d});
  endtask : wr
  task automatic rc(input int p, input logic [8:0] i, input logic [7:0] e);
    ahb(1'b0, adr(p, i), 32'h0);
    comparisons++;
    if (q !== {24'h0, e}) begin
      err_total++;
      $display("mismatch t=%0t addr %h got %h exp %h", $time, adr(p, i), q, e);
    end
  endtask : rc
  task automatic t_regs();
    for (logic [8:0] i = 9'h060; i < 9'h06A; i++) begin
      wr(0, i, 8'hFF);
      rc(0, i, 8'h00);
    end
    $display("test regs done");
  endtask : t_regs
  task automatic t_mon();
    logic [7:0] m;
    m = 8'hB4;
    wr(0, 9'h07E, 8'h05);
    // a later byte on another slot must not disturb the capture
    for (int n = 0; n < 16; n++) begin
      v           = '0;
      v.mon_valid = 1'b1;
      v.mon_slot  = (n < 8) ? 5'h05 : 5'h06;
      v.mon_idx   = 3'(n);
      v.mon_bit   = (n < 8) ? m[7 - n] : 1'b1;
      u_troc_line_model.pulse(0, v);
    end
    rc(0, 9'h060, 8'hB4);
    // port 0 now holds a nonzero byte, so aliasing onto it would show
    rc(1, 9'h060, 8'h00);
    rc(2, 9'h060, 8'h00);
    rc(4, 9'h060, 8'h00);
    $display("test monitor done");
  endtask : t_mon
  task automatic dl(input logic [7:0] d, input int n, input logic mf);
    for (int k = 0; k < n; k++) begin
      v          = '0;
      v.dl_valid = 1'b1;
      v.dl_bit   = d[k];
      v.mf_start = mf && (k == n - 1);
      u_troc_line_model.pulse(0, v);
    end
  endtask : dl
  task automatic t_dl();
    dl(8'h35, 8, 1'b0);
    rc(0, 9'h062, 8'h35);
    wr(0, 9'h07F, 8'h01);
    dl(8'h2A, 6, 1'b0);
    rc(0, 9'h062, 8'h35);
    dl(8'h2D, 6, 1'b1);
    rc(0, 9'h062, 8'h2D);
    $display("test data link done");
  endtask : t_dl
  task automatic t_boc();
    for (int p = 0; p < 2; p++) begin
      v           = '0;
      v.boc_valid = 1'b1;
      v.boc_code  = (p == 0) ? 6'h2A : 6'h11;
      u_troc_line_model.pulse(p, v);
    end
    rc(0, 9'h063, 8'h2A);
    rc(1, 9'h063, 8'h11);
    $display("test code done");
  endtask : t_boc
  task automatic t_slc();
    logic [23:0] s;
    s = 24'hC3A55A;
    wr(0, 9'h07F, 8'h02);
    for (int k = 0; k < 24; k++) begin
      v           = '0;
      v.slc_valid = 1'b1;
      v.slc_bit   = s[k];
      v.slc_end   = (k == 23);
      u_troc_line_model.pulse(0, v);
    end
    rc(0, 9'h064, 8'h5A);
    rc(0, 9'h065, 8'hA5);
    rc(0, 9'h066, 8'hC3);
    $display("test slc done");
  endtask : t_slc
  task automatic ts0(input logic [3:0] f, input logic [7:0] b);
    v           = '0;
    v.ts0_valid = 1'b1;
    v.ts0_align = ~f[0];
    v.ts0_frame = f;
    v.ts0_byte  = b;
    u_troc_line_model.pulse(0, v);
  endtask : ts0
  task automatic t_e1();
    wr(0, 9'h080, 8'h01);
    wr(0, 9'h081, 8'h08);
    rc(0, 9'h063, 8'h00);
    ts0(4'h0, 8'h9B);
    ts0(4'h5, 8'h50);
    ts0(4'h3, 8'hA5);
    rc(0, 9'h064, 8'h9B);
    rc(0, 9'h065, 8'hA5);
    rc(0, 9'h066, 8'h01);
    rc(0, 9'h067, 8'h02);
    rc(0, 9'h068, 8'h02);
    rc(0, 9'h069, 8'h04);
    $display("test e1 words done");
  endtask : t_e1
  task automatic tmo(input int n, input logic sy);
    for (int k = 0; k < n; k++) begin
      v             = '0;
      v.crc_timeout = ~sy;
      v.crc_sync    = sy;
      u_troc_line_model.pulse(0, v);
    end
  endtask : tmo
  task automatic t_csc();
    u_troc_line_model.level(3'h5);
    rc(0, 9'h062, 8'h05);
    u_troc_line_model.level(3'h2);
    tmo(5, 1'b0);
    rc(0, 9'h062, 8'h1A);
    tmo(1, 1'b1);
    rc(0, 9'h062, 8'h02);
    tmo(70, 1'b0);
    rc(0, 9'h062, 8'hFA);
    // host gives up the crc-4 search once the count has run out
    wr(0, 9'h081, 8'h00);
    rc(0, 9'h062, 8'h02);
    $display("test sync count done");
  endtask : t_csc
  initial begin
    repeat (20) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    t_regs();
    t_mon();
    t_dl();
    t_boc();
    t_slc();
    t_e1();
    t_csc();
    end_sim();
  end
endmodule : troc_rx_capture_test
